/* File: inc/sdpin_pkg.sv */
package sdpin_pkg;

  // ----------------------------------------------------------------
  // Clock rates and card clock limits
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 10_000_000;
  localparam int unsigned LINK_CLK_HZ = 8_000_000;
  localparam int unsigned CARD_CLK_MAX_MHZ = 48;
  localparam int unsigned CARD_CLK_MAX_HZ = CARD_CLK_MAX_MHZ * 1_000_000;
  // Least half period, in link cycles, that keeps the card clock legal
  localparam int unsigned CLK_HALF_LEGAL =
    (LINK_CLK_HZ + 2 * CARD_CLK_MAX_HZ - 1) / (2 * CARD_CLK_MAX_HZ);
  // Pin filter latency; inputs are taken this many cycles after the rise
  localparam int unsigned SAMPLE_PHASE = 3;
  // Half period must also leave room for the filter latency
  localparam int unsigned CLK_HALF_FLOOR =
    (CLK_HALF_LEGAL > SAMPLE_PHASE + 1) ? CLK_HALF_LEGAL : SAMPLE_PHASE + 1;
  localparam int unsigned CLK_HALF_DEF = 4;

  // ----------------------------------------------------------------
  // Frame sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_LANES = 4;
  localparam int unsigned CMD_BITS = 48;
  localparam int unsigned RESP_BITS = 48;
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned WORD_NIBS = WORD_BITS / DATA_LANES;
  localparam int unsigned WR_NIBS = WORD_NIBS + 2;
  localparam int unsigned RESP_WAIT_DEF = 64;
  localparam logic [3:0] NIB_START = 4'h0;
  localparam logic [3:0] NIB_END = 4'hF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_PWR_EN_N = 1'b1;
  localparam logic RST_PULLUP_EN = 1'b1;
  localparam logic [3:0] RST_DAT_OUT = 4'hF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CMD_BITS-1:0] frame;
    logic want_resp;
    logic data_en;
    logic data_wr;
    logic [WORD_BITS-1:0] wdata;
  } sdpin_req_t;

  typedef struct packed {
    logic [RESP_BITS-1:0] resp;
    logic [WORD_BITS-1:0] rdata;
    logic timeout;
  } sdpin_rsp_t;

  // Link sequencer, Gray codes along the usual path
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_CMD = 3'h1,
    L_RWAIT = 3'h3,
    L_RESP = 3'h2,
    L_DWR = 3'h6,
    L_DWAIT = 3'h7,
    L_DRD = 3'h5,
    L_DONE = 3'h4
  } sdpin_lstate_t;

endpackage

/* File: verilog/sdpin_sync.sv */
// Three-stage pin filter; an output bit changes once stages two and three agree
module sdpin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous in, filtered out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1_ff; // Metastability catcher, read only by stage two
  logic [W-1:0] stage2_ff;
  logic [W-1:0] stage3_ff;
  logic [W-1:0] q_ff;

  // Chain has no reset so it also serves to bring a reset across
  always_ff @(posedge clk) begin
    stage1_ff <= d;
    stage2_ff <= stage1_ff;
    stage3_ff <= stage2_ff;
  end

  // Take a bit only where the two late stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff <= INIT;
    end else begin
      q_ff <= (stage2_ff & ~(stage2_ff ^ stage3_ff)) | (q_ff & (stage2_ff ^ stage3_ff));
    end
  end

  assign q = q_ff;

endmodule

/* File: verilog/sdpin_host.sv */
// Contract
// [RL1] One bit per card clock on each line
// [RL2] Card clock never above 48 MHz
// [RL3] Command line open drain during initialization
// [RL4] Command line push-pull after initialization
// [RL5] Data lines always driven push-pull
// [RL6] Four data lines only, upper four unused
// [RL7] Low card detect means card present
// [RL8] Sample and report write-protect tab
// [RL9] Drive low-active card power enable
// [RL10] Activity LED follows bus transfers
// [RL11] Pull-ups off in high-speed mode
// [RL12] No clock or drive without card power
module sdpin_host #(
  parameter int unsigned CLK_HALF = sdpin_pkg::CLK_HALF_DEF,
  parameter int unsigned RESP_WAIT = sdpin_pkg::RESP_WAIT_DEF
) (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link clock, base of the card clock
  input wire logic link_clk,
  // User request side
  input wire logic req_valid,
  output logic req_ready,
  input wire sdpin_pkg::sdpin_req_t req_data,
  output logic rsp_valid,
  output sdpin_pkg::sdpin_rsp_t rsp_data,
  // User control and status
  input wire logic power_request,
  input wire logic init_mode,
  input wire logic high_speed_mode,
  output logic card_present,
  output logic card_write_protected,
  // Card slot pins
  output logic card_clk,
  input wire logic card_cmd_in,
  output logic card_cmd_out,
  output logic card_cmd_oe,
  input wire logic [3:0] card_data_in,
  output logic [3:0] card_data_out,
  output logic [3:0] card_data_oe,
  input wire logic card_present_n,
  input wire logic card_write_protect,
  output logic card_power_enable_n,
  output logic card_pullup_en,
  output logic card_led
);
  import sdpin_pkg::*;

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  // Half period is forced up to the legal floor whatever CLK_HALF says
  localparam int unsigned HALF = (CLK_HALF < CLK_HALF_FLOOR) ? CLK_HALF_FLOOR : CLK_HALF; // [RL2]
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
  localparam logic [7:0] SAMPLE_AT = 8'(SAMPLE_PHASE);
  localparam logic [7:0] WAIT_LOAD = 8'(RESP_WAIT);

  // ----------------------------------------------------------------
  // Reference domain signals
  // ----------------------------------------------------------------
  logic [1:0] slot_q; // Filtered detect and write-protect
  logic pwr_on_ff; // Card powered and present
  logic busy_ff; // A request is out on the link
  logic req_tgl_ff; // Flips once per accepted request
  logic done_seen_ff; // Last link completion taken
  logic done_q; // Link completion toggle, filtered
  logic rsp_valid_ff;
  sdpin_rsp_t rsp_ff;
  sdpin_req_t req_hold_ff; // Held steady while the link reads it
  logic present_ff;
  logic wp_ff;
  logic pwr_en_n_ff;
  logic pullup_ff;
  logic led_ff;

  // ----------------------------------------------------------------
  // Link domain signals
  // ----------------------------------------------------------------
  logic [1:0] lrst_q; // Reset brought into the link domain
  logic lrst_n;
  logic [7:0] lin_q; // Filtered: req toggle, power, init, cmd, data
  logic req_s, active_s, init_s, cmd_s;
  logic [3:0] dat_s;
  sdpin_lstate_t st_ff;
  logic req_seen_ff;
  logic done_tgl_ff;
  sdpin_rsp_t lrsp_ff; // Result, held until the next request
  logic [CMD_BITS-1:0] cmd_sh_ff;
  logic [4*WR_NIBS-1:0] dat_sh_ff;
  logic [6:0] cnt_ff;
  logic [7:0] wait_ff;
  logic [7:0] div_ff;
  logic cclk_ff;
  logic cmd_o_ff, cmd_oe_ff;
  logic [3:0] dat_o_ff, dat_oe_ff;
  logic run, fall, take;

  // ----------------------------------------------------------------
  // Pin filters in the reference domain
  // ----------------------------------------------------------------
  sdpin_sync #(.W(2), .INIT(2'b01)) u_slot_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({card_write_protect, card_present_n}),
    .q(slot_q)
  );

  // Completion toggle from the link domain
  sdpin_sync #(.W(1), .INIT(1'b0)) u_done_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(done_tgl_ff),
    .q(done_q)
  );

  // Presence is the low level of the detect pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      present_ff <= 1'b0;
    end else begin
      present_ff <= ~slot_q[0]; // [RL7]
    end
  end

  // Write-protect tab state, reported as a level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_ff <= 1'b0;
    end else begin
      wp_ff <= slot_q[1]; // [RL8]
    end
  end

  // Power only when asked and a card sits in the slot
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwr_on_ff <= 1'b0;
      pwr_en_n_ff <= RST_PWR_EN_N;
    end else begin
      pwr_on_ff <= power_request & ~slot_q[0]; // [RL12]
      pwr_en_n_ff <= ~(power_request & ~slot_q[0]); // [RL9]
    end
  end

  // Pull-ups dropped once the fast mode is in force
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pullup_ff <= RST_PULLUP_EN;
    end else begin
      pullup_ff <= ~high_speed_mode; // [RL11]
    end
  end

  // ----------------------------------------------------------------
  // Request handshake, reference side
  // ----------------------------------------------------------------
  // One request at a time; a powered slot is needed to start one
  assign req_ready = ~busy_ff & pwr_on_ff;

  // Accept, hold, and flip the request toggle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      req_hold_ff <= '0;
    end else if (req_valid && req_ready) begin
      busy_ff <= 1'b1;
      req_tgl_ff <= ~req_tgl_ff;
      req_hold_ff <= req_data;
    end else if (done_q != done_seen_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // Completion: link result is steady by now, so it is copied whole
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_seen_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (done_q != done_seen_ff) begin
        done_seen_ff <= done_q;
        rsp_valid_ff <= 1'b1;
        rsp_ff <= lrsp_ff;
      end
    end
  end

  // Registered from busy_ff: lit one cycle after a request goes out, until one cycle after it ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      led_ff <= 1'b0;
    end else begin
      led_ff <= busy_ff; // [RL10]
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the link domain
  // ----------------------------------------------------------------
  // Reset crossing; its own filter runs unreset and settles in four edges
  sdpin_sync #(.W(2), .INIT(2'b00)) u_lrst_sync (
    .clk(link_clk),
    .rst_n(1'b1),
    .d({rst_n, rst_n}),
    .q(lrst_q)
  );
  assign lrst_n = lrst_q[0];

  // Levels from the reference side and the card's own pins
  sdpin_sync #(.W(8), .INIT(8'hF0)) u_link_sync (
    .clk(link_clk),
    .rst_n(lrst_n),
    .d({card_data_in, card_cmd_in, init_mode, pwr_on_ff, req_tgl_ff}),
    .q(lin_q)
  );
  assign req_s = lin_q[0];
  assign active_s = lin_q[1];
  assign init_s = lin_q[2];
  assign cmd_s = lin_q[3];
  assign dat_s = lin_q[7:4];

  // ----------------------------------------------------------------
  // Card clock divider
  // ----------------------------------------------------------------
  // Clock runs only inside a transfer and with the card powered
  assign run = active_s && st_ff != L_IDLE && st_ff != L_DONE; // [RL12]
  // Last link cycle of the high half: outputs move with the fall
  assign fall = run && cclk_ff && div_ff == HALF_LAST; // [RL1]
  // Inputs are taken once the filter has caught the rise
  assign take = run && cclk_ff && div_ff == SAMPLE_AT; // [RL1]

  // Divide the link clock; parked low when stopped
  always_ff @(posedge link_clk) begin
    if (!lrst_n || !run) begin
      div_ff <= 8'h00;
      cclk_ff <= 1'b0;
    end else if (div_ff == HALF_LAST) begin
      div_ff <= 8'h00;
      cclk_ff <= ~cclk_ff; // [RL2]
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  // Command, optional response, optional one-word data frame
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      st_ff <= L_IDLE;
      req_seen_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      lrsp_ff <= '0;
      cmd_sh_ff <= '0;
      dat_sh_ff <= '0;
      cnt_ff <= 7'h00;
      wait_ff <= 8'h00;
      cmd_o_ff <= 1'b1;
      cmd_oe_ff <= 1'b0;
      dat_o_ff <= RST_DAT_OUT;
      dat_oe_ff <= 4'h0;
    end else if (!active_s && st_ff != L_IDLE && st_ff != L_DONE) begin
      // Power lost mid-transfer: let go of every line and report
      cmd_oe_ff <= 1'b0; // [RL12]
      dat_oe_ff <= 4'h0; // [RL12]
      lrsp_ff.timeout <= 1'b1;
      st_ff <= L_DONE;
    end else begin
      case (st_ff)
        L_IDLE: begin
          if (req_s != req_seen_ff) begin
            req_seen_ff <= req_s;
            lrsp_ff <= '0;
            if (!active_s) begin
              // Slot went dark before the start
              lrsp_ff.timeout <= 1'b1;
              st_ff <= L_DONE;
            end else begin
              // First bit goes out while the clock is still low
              cmd_sh_ff <= {req_hold_ff.frame[CMD_BITS-2:0], 1'b1};
              cnt_ff <= 7'(CMD_BITS - 1);
              cmd_o_ff <= init_s ? 1'b0 : req_hold_ff.frame[CMD_BITS-1]; // [RL3]
              cmd_oe_ff <= init_s ? ~req_hold_ff.frame[CMD_BITS-1] : 1'b1; // [RL3] [RL4]
              st_ff <= L_CMD;
            end
          end
        end
        L_CMD: begin
          if (fall) begin
            if (cnt_ff == 7'h00) begin
              // Frame sent; hand the line back
              cmd_oe_ff <= 1'b0;
              cmd_o_ff <= 1'b1;
              wait_ff <= WAIT_LOAD;
              if (req_hold_ff.want_resp) begin
                st_ff <= L_RWAIT;
              end else if (req_hold_ff.data_en) begin
                st_ff <= req_hold_ff.data_wr ? L_DWR : L_DWAIT;
              end else begin
                st_ff <= L_DONE;
              end
              dat_sh_ff <= {NIB_START, req_hold_ff.wdata, NIB_END};
              cnt_ff <= 7'(WR_NIBS);
            end else begin
              // Next bit, open drain only pulls low in init
              cmd_o_ff <= init_s ? 1'b0 : cmd_sh_ff[CMD_BITS-1]; // [RL3] [RL4]
              cmd_oe_ff <= init_s ? ~cmd_sh_ff[CMD_BITS-1] : 1'b1; // [RL3] [RL4]
              cmd_sh_ff <= {cmd_sh_ff[CMD_BITS-2:0], 1'b1};
              cnt_ff <= cnt_ff - 7'h01;
            end
          end
        end
        L_RWAIT: begin
          if (take) begin
            if (!cmd_s) begin
              // Start bit seen; it counts as the first response bit
              cmd_sh_ff <= '0;
              cnt_ff <= 7'(RESP_BITS - 2);
              st_ff <= L_RESP;
            end else if (wait_ff == 8'h00) begin
              // Card stayed silent
              lrsp_ff.timeout <= 1'b1;
              st_ff <= L_DONE;
            end else begin
              wait_ff <= wait_ff - 8'h01;
            end
          end
        end
        L_RESP: begin
          if (take) begin
            cmd_sh_ff <= {cmd_sh_ff[CMD_BITS-2:0], cmd_s}; // [RL1]
            cnt_ff <= cnt_ff - 7'h01;
            if (cnt_ff == 7'h00) begin
              lrsp_ff.resp <= {cmd_sh_ff[RESP_BITS-2:0], cmd_s};
              wait_ff <= WAIT_LOAD;
              cnt_ff <= 7'(WR_NIBS);
              if (req_hold_ff.data_en) begin
                st_ff <= req_hold_ff.data_wr ? L_DWR : L_DWAIT;
              end else begin
                st_ff <= L_DONE;
              end
            end
          end
        end
        L_DWR: begin
          if (fall) begin
            if (cnt_ff == 7'h00) begin
              // End nibble has had its cycle; release
              dat_oe_ff <= 4'h0;
              dat_o_ff <= RST_DAT_OUT;
              st_ff <= L_DONE;
            end else begin
              // One nibble per clock, all four lanes driven both ways
              dat_o_ff <= dat_sh_ff[4*WR_NIBS-1 -: 4]; // [RL1] [RL6]
              dat_oe_ff <= 4'hF; // [RL5]
              dat_sh_ff <= {dat_sh_ff[4*WR_NIBS-5:0], 4'h0};
              cnt_ff <= cnt_ff - 7'h01;
            end
          end
        end
        L_DWAIT: begin
          if (take) begin
            if (dat_s == NIB_START) begin
              cnt_ff <= 7'(WORD_NIBS - 1);
              st_ff <= L_DRD;
            end else if (wait_ff == 8'h00) begin
              lrsp_ff.timeout <= 1'b1;
              st_ff <= L_DONE;
            end else begin
              wait_ff <= wait_ff - 8'h01;
            end
          end
        end
        L_DRD: begin
          if (take) begin
            // Nibbles arrive high first; end nibble is not checked
            lrsp_ff.rdata <= {lrsp_ff.rdata[WORD_BITS-5:0], dat_s}; // [RL1] [RL6]
            cnt_ff <= cnt_ff - 7'h01;
            if (cnt_ff == 7'h00) begin
              st_ff <= L_DONE;
            end
          end
        end
        L_DONE: begin
          // Result is complete; one flip tells the reference side
          done_tgl_ff <= ~done_tgl_ff;
          st_ff <= L_IDLE;
        end
        default: begin
          st_ff <= L_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign card_clk = cclk_ff;
  assign card_cmd_out = cmd_o_ff;
  assign card_cmd_oe = cmd_oe_ff;
  // Only four lanes exist; the wide-bus lanes have no pins at all
  assign card_data_out = dat_o_ff; // [RL6]
  assign card_data_oe = dat_oe_ff; // [RL5]
  assign card_present = present_ff;
  assign card_write_protected = wp_ff;
  assign card_power_enable_n = pwr_en_n_ff;
  assign card_pullup_en = pullup_ff;
  assign card_led = led_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_ff;

endmodule

/* File: bench/sdpin_host_sva.sv */
// ----
// Pin interface checks
// ----
module sdpin_host_sva (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  // Request and control
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic power_request,
  input wire logic init_mode,
  input wire logic high_speed_mode,
  input wire logic card_present,
  // Card pins
  input wire logic card_clk,
  input wire logic card_cmd_out,
  input wire logic card_cmd_oe,
  input wire logic [3:0] card_data_oe,
  input wire logic card_present_n,
  input wire logic card_power_enable_n,
  input wire logic card_pullup_en,
  input wire logic card_led
);
  // Filter depth is three stages, so eight cycles leaves margin
  property p_present;
    @(posedge ref_clk) disable iff (!rst_n) !card_present_n [*8] |=> card_present;
  endproperty
  a_present: assert property (p_present) else $error("card flag late");
  property p_pwr_off;
    @(posedge ref_clk) disable iff (!rst_n) !power_request |=> card_power_enable_n;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power stays on");
  property p_led;
    @(posedge ref_clk) disable iff (!rst_n) req_valid && req_ready |-> ##[1:2] card_led;
  endproperty
  a_led: assert property (p_led) else $error("led not lit");
  property p_pullup;
    @(posedge ref_clk) disable iff (!rst_n) $rose(high_speed_mode) |=> !card_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullups still on");
  // Crossing of the power state takes a few link cycles
  property p_quiet;
    @(posedge link_clk) disable iff (!rst_n)
      card_power_enable_n [*8] |-> !card_clk && !card_cmd_oe && card_data_oe == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus active unpowered");
  property p_half;
    @(posedge link_clk) disable iff (!rst_n) $rose(card_clk) |-> card_clk [*4];
  endproperty
  a_half: assert property (p_half) else $error("card clock too fast");
  property p_bit_edge;
    @(posedge link_clk) disable iff (!rst_n)
      card_cmd_oe && $past(card_cmd_oe) && $changed(card_cmd_out) |-> !card_clk;
  endproperty
  a_bit_edge: assert property (p_bit_edge) else $error("bit moved mid clock");
  property p_od;
    @(posedge link_clk) disable iff (!rst_n) init_mode [*8] ##0 card_cmd_oe |-> !card_cmd_out;
  endproperty
  a_od: assert property (p_od) else $error("command drove high");
  property p_lanes;
    @(posedge link_clk) disable iff (!rst_n) card_data_oe == 4'h0 || card_data_oe == 4'hF;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane enables split");
endmodule

bind sdpin_host sdpin_host_sva u_sva (.ref_clk(ref_clk), .link_clk(link_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .power_request(power_request),
  .init_mode(init_mode), .high_speed_mode(high_speed_mode), .card_present(card_present),
  .card_clk(card_clk), .card_cmd_out(card_cmd_out), .card_cmd_oe(card_cmd_oe),
  .card_data_oe(card_data_oe), .card_present_n(card_present_n),
  .card_power_enable_n(card_power_enable_n), .card_pullup_en(card_pullup_en),
  .card_led(card_led));

/* File: bench/sdpin_card_model.sv */
// Card in the slot, samples on rise and drives after fall
module sdpin_card_model (
  // Slot wires
  input wire logic card_clk,
  input wire logic host_cmd_oe,
  input wire logic cmd_wire,
  input wire logic [3:0] dat_wire,
  // Scenario controls
  input wire logic od_mode,
  input wire logic resp_on,
  input wire logic [1:0] dmode,
  input wire logic [5:0] gap,
  input wire logic [47:0] resp_bits,
  input wire logic [31:0] rd_word,
  // Card drive and capture
  output logic cmd_oe,
  output logic cmd_out,
  output logic dat_oe,
  output logic [3:0] dat_out,
  output logic [47:0] got_frame,
  output logic [31:0] got_word
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_oe = 1'b0;
    cmd_out = 1'b0;
    dat_oe = 1'b0;
    dat_out = 4'h0;
    got_word = '0;
    forever begin
      // Frame opens at the first rise the host drives
      do @(posedge card_clk); while (host_cmd_oe !== 1'b1);
      got_frame = {47'h0, cmd_wire};
      repeat (47) begin
        @(posedge card_clk);
        got_frame = {got_frame[46:0], cmd_wire};
      end
      if (resp_on) begin
        repeat (gap) @(negedge card_clk);
        for (int i = 47; i >= 0; i--) begin
          cmd_oe = od_mode ? ~resp_bits[i] : 1'b1;
          cmd_out = od_mode ? 1'b0 : resp_bits[i];
          @(negedge card_clk);
        end
        cmd_oe = 1'b0;
      end
      // Read data: start nibble, then the word high nibble first
      if (dmode == 2'd1) begin
        repeat (gap) @(negedge card_clk);
        dat_oe = 1'b1;
        dat_out = 4'h0;
        for (int k = 7; k >= 0; k--) begin
          @(negedge card_clk);
          dat_out = rd_word[4*k +: 4];
        end
        @(negedge card_clk);
        dat_oe = 1'b0;
      end
      // Write data: lines idle high, so all-low is the start nibble
      if (dmode == 2'd2) begin
        do @(posedge card_clk); while (dat_wire !== 4'h0);
        repeat (8) begin
          @(posedge card_clk);
          got_word = {got_word[27:0], dat_wire};
        end
      end
    end
  end
endmodule

/* File: bench/sd_card_host_pin_interface_tb.sv */
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); end end
module sd_card_host_pin_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sdpin_pkg::*;
  // ----
  // Wires, clocks and parts
  // ----
  logic ref_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic req_valid, req_ready, rsp_valid, power_request, init_mode, high_speed_mode;
  logic card_present, card_wp, card_clk, h_cmd_out, h_cmd_oe, present_n, wp, pwr_n, pull, led;
  logic [3:0] h_dat_out, h_dat_oe, dat_wire, m_dat_out;
  logic cmd_wire, m_cmd_oe, m_cmd_out, m_dat_oe, resp_on;
  logic [1:0] dmode;
  logic [5:0] gap;
  logic [47:0] resp_bits, got_frame;
  logic [31:0] rd_word, got_word;
  sdpin_req_t req_data;
  sdpin_rsp_t rsp_data;
  logic [80:0] exp_q[$]; // Expected timeout, response, read word
  int n_fail = 0, total_checks = 0, seed = 8;
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  // Released lines float to the pull-up level
  assign cmd_wire = h_cmd_oe ? h_cmd_out : (m_cmd_oe ? m_cmd_out : 1'b1);
  assign dat_wire = (h_dat_oe & h_dat_out) | (~h_dat_oe & (m_dat_oe ? m_dat_out : 4'hF));
  sdpin_host #(.CLK_HALF(CLK_HALF_DEF), .RESP_WAIT(RESP_WAIT_DEF)) u_dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .link_clk(link_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .power_request(power_request), .init_mode(init_mode), .high_speed_mode(high_speed_mode),
    .card_present(card_present), .card_write_protected(card_wp), .card_clk(card_clk),
    .card_cmd_in(cmd_wire), .card_cmd_out(h_cmd_out), .card_cmd_oe(h_cmd_oe),
    .card_data_in(dat_wire), .card_data_out(h_dat_out), .card_data_oe(h_dat_oe),
    .card_present_n(present_n), .card_write_protect(wp), .card_power_enable_n(pwr_n),
    .card_pullup_en(pull), .card_led(led));
  sdpin_card_model u_card (.card_clk(card_clk), .host_cmd_oe(h_cmd_oe), .cmd_wire(cmd_wire),
    .dat_wire(dat_wire), .od_mode(init_mode), .resp_on(resp_on), .dmode(dmode), .gap(gap),
    .resp_bits(resp_bits), .rd_word(rd_word), .cmd_oe(m_cmd_oe), .cmd_out(m_cmd_out),
    .dat_oe(m_dat_oe), .dat_out(m_dat_out), .got_frame(got_frame), .got_word(got_word));
  // ----
  // Tasks
  // ----
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One request; the card answer is set up before the offer
  task automatic do_req(input logic want, input logic [1:0] dm, input logic ron);
    sdpin_req_t r;
    logic [63:0] rv;
    logic [80:0] e;
    int i;
    bit lit;
    rv = {$random(seed), $random(seed)};
    r.frame = {1'b0, rv[46:0]};
    r.want_resp = want;
    r.data_en = (dm != 2'd0);
    r.data_wr = (dm == 2'd2);
    r.wdata = rv[63:32];
    rv = {$random(seed), $random(seed)};
    resp_bits = {1'b0, rv[46:0]};
    rd_word = rv[63:32];
    dmode = dm;
    resp_on = ron;
    exp_q.push_back({want & ~ron, resp_bits, rd_word});
    req_data = r;
    req_valid = 1'b1;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    if (req_ready !== 1'b1) begin
      n_fail++;
      close_out();
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    lit = 1'b0;
    for (i = 0; i < 5000 && rsp_valid !== 1'b1; i++) begin
      @(negedge ref_clk);
      lit |= (led === 1'b1);
    end
    if (rsp_valid !== 1'b1) begin
      n_fail++;
      close_out();
    end
    e = exp_q.pop_front();
    `CHK("timeout", e[80], rsp_data.timeout)
    `CHK("led", 1'b1, lit)
    `CHK("frame", r.frame, got_frame)
    if (want && ron) `CHK("resp", e[79:32], rsp_data.resp)
    if (dm == 2'd1) `CHK("rdata", e[31:0], rsp_data.rdata)
    if (dm == 2'd2) `CHK("wdata", r.wdata, got_word)
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    logic [3:0] wnt, ron;
    logic [7:0] dms;
    // Write-only request gets no answer, else the card misses the data frame
    wnt = 4'b1011;
    ron = 4'b0011;
    dms = 8'b00_10_01_00;
    req_valid = 1'b0;
    req_data = '0;
    power_request = 1'b1;
    init_mode = 1'b1;
    high_speed_mode = 1'b0;
    present_n = 1'b1;
    wp = 1'b0;
    resp_on = 1'b0;
    dmode = 2'd0;
    gap = 6'd2;
    resp_bits = '0;
    rd_word = '0;
    // Long enough for the link side to see reset too
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (12) @(negedge ref_clk);
    `CHK("present", 1'b0, card_present)
    `CHK("power", 1'b1, pwr_n)
    `CHK("ready", 1'b0, req_ready)
    wp = 1'b1;
    present_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK("wp", 1'b1, card_wp)
    `CHK("present", 1'b1, card_present)
    `CHK("power", 1'b0, pwr_n)
    wp = 1'b0;
    do_req(1'b1, 2'd0, 1'b1);
    do_req(1'b1, 2'd1, 1'b1);
    init_mode = 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK("wp", 1'b0, card_wp)
    // Answer only, read, bare write, no answer at all
    for (int m = 0; m < 4; m++) do_req(wnt[m], dms[2*m +: 2], ron[m]);
    gap = 6'd40;
    do_req(1'b1, 2'd1, 1'b1);
    high_speed_mode = 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    `CHK("pullup", 1'b0, pull)
    do_req(1'b1, 2'd2, 1'b1);
    power_request = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("power", 1'b1, pwr_n)
    req_valid = 1'b1;
    repeat (40) begin
      @(negedge ref_clk);
      `CHK("refused", 1'b0, rsp_valid | req_ready)
    end
    req_valid = 1'b0;
    close_out();
  end
endmodule
